// ### design/cfc_codec.sv
/*
 * CAN 2.0B bit-level frame codec: stuffing, fields, CRC, ACK, EOF,
 * intermission, error and overload flags.
 * Assumes bit_tick marks each sampled bit from a bit-timing unit on clk,
 * rx_bit is that sample, and tx_bit is driven onto the bus by that unit.
 */
`timescale 1ns/100ps
`include "cfc_defs.svh"
module cfc_codec (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic bit_tick, // one pulse per sampled bit
	input wire logic rx_bit, // sampled bus level
	input wire logic err_passive, // node is error-passive
	input wire logic tx_req, // hold high until tx_done
	input wire logic tx_ide, // extended format
	input wire logic tx_rtr, // remote frame
	input wire logic [28:0] tx_id, // standard id in [10:0]
	input wire logic [3:0] tx_dlc, // data length code
	input wire logic [63:0] tx_data, // last byte in [7:0]
	output logic tx_bit, // level to drive on bus
	output logic tx_done, // frame sent and acknowledged
	output logic tx_lost, // arbitration lost
	output logic rx_valid, // received frame good
	output logic rx_ide, // received extended format
	output logic rx_rtr, // received remote
	output logic [28:0] rx_id, // received identifier
	output logic [3:0] rx_dlc, // received length code
	output logic [63:0] rx_data, // last byte in [7:0]
	output logic err_bit, // bit error
	output logic err_stuff, // stuff error
	output logic err_crc, // crc error
	output logic err_form, // form error
	output logic err_ack, // no acknowledge
	output logic ovl_start // overload flag begins
);
	cfc_pkg::cfc_state_e state_r, state_nxt;
	logic [6:0] pos_r, pos_nxt;
	logic [2:0] run_r, run_nxt;
	logic [3:0] cnt_r, cnt_nxt, dom_r, dom_nxt;
	logic last_r, last_nxt, txing_r, txing_nxt, done_r, done_nxt;
	logic ovl_r, ovl_nxt, passive_r, passive_nxt, crc_bad_r, crc_bad_nxt;
	logic tx_bit_r, tx_bit_nxt;
	logic [102:0] tx_sh_r, tx_sh_nxt;
	logic [28:0] id_r, id_nxt;
	logic ide_r, ide_nxt, rtr_r, rtr_nxt;
	logic [3:0] dlc_r, dlc_nxt;
	logic [63:0] data_r, data_nxt;
	logic [7:0] pulse_r, pulse_nxt;
	logic sof, launch, fault, ovl_go, crc_en, crc_clr;
	logic [14:0] crc_nxt;

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	function automatic logic [6:0] data_bits(input logic rtr, input logic [3:0] dlc);
		if (rtr)
			data_bits = 7'h00;
		else if (dlc[3])
			data_bits = `CFC_MAX_DATA;
		else
			data_bits = {dlc, 3'h0};
	endfunction

	logic [6:0] hdr_len, nd_bits, data_end;
	logic [3:0] dlc_in;
	logic in_id, is_rtr, is_ide, in_dlc, in_data, last_data, crc_start, arb_zone;
	logic stuff_due, slip;
	logic [102:0] sh_plain, sh_adv, tx_load;
	logic [63:0] tx_payload;
	logic [18:0] std_hdr;
	logic [38:0] ext_hdr;

	assign hdr_len = ide_r ? `CFC_EXT_HDR : `CFC_STD_HDR;
	assign in_id = (pos_r != 7'h00 && pos_r <= `CFC_POS_ID_END)
		|| (ide_r && pos_r > `CFC_POS_IDE && pos_r <= `CFC_POS_EID_END);
	assign is_rtr = ide_r ? (pos_r == `CFC_POS_XRTR) : (pos_r == `CFC_POS_SRR_RTR);
	assign is_ide = pos_r == `CFC_POS_IDE;
	assign in_dlc = pos_r >= hdr_len - `CFC_DLC_LEN && pos_r < hdr_len;
	assign dlc_in = in_dlc ? {dlc_r[2:0], rx_bit} : dlc_r;
	assign nd_bits = data_bits(rtr_r, dlc_in);
	assign data_end = hdr_len + nd_bits;
	assign in_data = pos_r >= hdr_len && pos_r < data_end;
	assign crc_start = pos_r + 7'h01 == data_end;
	assign last_data = pos_r + 7'h01 == data_end + `CFC_CRC_LEN;
	assign arb_zone = pos_r <= `CFC_POS_IDE || (ide_r && pos_r <= `CFC_POS_XRTR);
	assign stuff_due = run_r == `CFC_STUFF_RUN;
	assign slip = txing_r && tx_bit_r != rx_bit;

	// transmit image: header then payload, msb first
	assign std_hdr = {1'b0, tx_id[10:0], tx_rtr, 1'b0, 1'b0, tx_dlc};
	assign ext_hdr = {1'b0, tx_id[28:18], 1'b1, 1'b1, tx_id[17:0], tx_rtr, 2'h0, tx_dlc};
	assign tx_payload = tx_data << (`CFC_MAX_DATA - data_bits(tx_rtr, tx_dlc));
	assign tx_load = tx_ide ? {ext_hdr, tx_payload} : {std_hdr, tx_payload, 20'h0};
	assign sh_plain = {tx_sh_r[101:0], 1'b0};
	assign sh_adv = crc_start ? {crc_nxt, 88'h0} : sh_plain;

	cfc_crc15 u_crc (
		.clk(clk),
		.reset(reset),
		.clr(crc_clr),
		.en(crc_en),
		.din(rx_bit),
		.crc_nxt(crc_nxt)
	);

	// ----------------------------------------
	// bit sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		pos_nxt = pos_r;
		run_nxt = run_r;
		last_nxt = last_r;
		cnt_nxt = cnt_r;
		dom_nxt = dom_r;
		txing_nxt = txing_r;
		done_nxt = done_r;
		ovl_nxt = ovl_r;
		passive_nxt = passive_r;
		crc_bad_nxt = crc_bad_r;
		tx_sh_nxt = tx_sh_r;
		tx_bit_nxt = tx_bit_r;
		id_nxt = id_r;
		ide_nxt = ide_r;
		rtr_nxt = rtr_r;
		dlc_nxt = dlc_r;
		data_nxt = data_r;
		pulse_nxt = 8'h00;
		crc_en = 1'b0;
		crc_clr = 1'b0;
		sof = 1'b0;
		launch = 1'b0;
		fault = 1'b0;
		ovl_go = 1'b0;
		if (bit_tick) begin
			case (state_r)
			cfc_pkg::st_idle: begin
				sof = !rx_bit;
				launch = rx_bit && tx_req;
			end
			cfc_pkg::st_frame: begin
				if (stuff_due) begin
					run_nxt = 3'h1;
					last_nxt = rx_bit;
					if (rx_bit == last_r) begin
						fault = 1'b1;
						pulse_nxt[1] = 1'b1;
					end else if (slip) begin
						fault = 1'b1;
						pulse_nxt[0] = 1'b1;
					end else if (done_r) begin
						state_nxt = cfc_pkg::st_crcdel;
						tx_bit_nxt = 1'b1;
					end else
						tx_bit_nxt = txing_r ? tx_sh_r[102] : 1'b1;
				end else begin
					run_nxt = (rx_bit == last_r) ? run_r + 3'h1 : 3'h1;
					last_nxt = rx_bit;
					pos_nxt = pos_r + 7'h01;
					crc_en = 1'b1;
					tx_sh_nxt = sh_adv;
					if (in_id)
						id_nxt = {id_r[27:0], rx_bit};
					if (is_rtr)
						rtr_nxt = rx_bit;
					if (is_ide)
						ide_nxt = rx_bit;
					dlc_nxt = dlc_in; // reserved bits taken as they come
					if (in_data)
						data_nxt = {data_r[62:0], rx_bit};
					if (txing_r && arb_zone && tx_bit_r && !rx_bit) begin
						txing_nxt = 1'b0;
						pulse_nxt[6] = 1'b1;
					end else if (slip) begin
						fault = 1'b1;
						pulse_nxt[0] = 1'b1;
					end
					if (last_data) begin
						done_nxt = 1'b1;
						crc_bad_nxt = crc_nxt != `CFC_CRC_GOOD;
					end
					if (run_nxt == `CFC_STUFF_RUN)
						tx_bit_nxt = txing_nxt ? !rx_bit : 1'b1;
					else if (last_data) begin
						state_nxt = cfc_pkg::st_crcdel;
						tx_bit_nxt = 1'b1;
					end else
						tx_bit_nxt = txing_nxt ? sh_adv[102] : 1'b1;
				end
			end
			cfc_pkg::st_crcdel: begin
				if (!rx_bit) begin
					fault = 1'b1;
					pulse_nxt[3] = 1'b1;
				end else begin
					state_nxt = cfc_pkg::st_ack;
					tx_bit_nxt = txing_r || crc_bad_r;
				end
			end
			cfc_pkg::st_ack: begin
				if (txing_r && rx_bit) begin
					fault = 1'b1;
					pulse_nxt[4] = 1'b1;
				end else begin
					state_nxt = cfc_pkg::st_ackdel;
					tx_bit_nxt = 1'b1;
				end
			end
			cfc_pkg::st_ackdel: begin
				if (!rx_bit) begin
					fault = 1'b1;
					pulse_nxt[3] = 1'b1;
				end else if (crc_bad_r && !txing_r) begin
					fault = 1'b1;
					pulse_nxt[2] = 1'b1;
				end else begin
					state_nxt = cfc_pkg::st_eof;
					cnt_nxt = 4'h0;
				end
			end
			cfc_pkg::st_eof: begin
				if (!rx_bit) begin
					if (cnt_r == `CFC_EOF_LAST && !txing_r)
						ovl_go = 1'b1;
					else begin
						fault = 1'b1;
						pulse_nxt[3] = 1'b1;
					end
				end else if (cnt_r == `CFC_EOF_LAST) begin
					state_nxt = cfc_pkg::st_inter;
					cnt_nxt = 4'h0;
					pulse_nxt[5] = txing_r;
					txing_nxt = 1'b0;
				end else begin
					cnt_nxt = cnt_r + 4'h1;
					pulse_nxt[7] = cnt_r == `CFC_EOF_VALID && !txing_r;
				end
			end
			cfc_pkg::st_inter: begin
				if (!rx_bit) begin
					if (cnt_r == `CFC_INTER_LAST)
						sof = 1'b1;
					else
						ovl_go = 1'b1;
				end else if (cnt_r == `CFC_INTER_LAST) begin
					state_nxt = cfc_pkg::st_idle;
					launch = tx_req;
				end else
					cnt_nxt = cnt_r + 4'h1;
			end
			cfc_pkg::st_flag: begin
				cnt_nxt = cnt_r + 4'h1;
				if (passive_r && !ovl_r) begin
					run_nxt = (run_r != 3'h0 && rx_bit == last_r) ? run_r + 3'h1 : 3'h1;
					last_nxt = rx_bit;
					if (run_nxt == `CFC_PASV_RUN) begin
						state_nxt = cfc_pkg::st_echo;
						dom_nxt = 4'h0;
					end
				end else if (cnt_r == `CFC_FLAG_LAST) begin
					state_nxt = cfc_pkg::st_echo;
					dom_nxt = `CFC_FLAG_LEN;
					tx_bit_nxt = 1'b1;
				end
			end
			cfc_pkg::st_echo: begin
				if (rx_bit) begin
					state_nxt = cfc_pkg::st_delim;
					cnt_nxt = 4'h1;
				end else begin
					pulse_nxt[3] = dom_r == `CFC_ECHO_MAX;
					if (dom_r <= `CFC_ECHO_MAX)
						dom_nxt = dom_r + 4'h1;
				end
			end
			cfc_pkg::st_delim: begin
				if (!rx_bit) begin
					if (cnt_r == `CFC_DELIM_LAST)
						ovl_go = 1'b1;
					else begin
						fault = 1'b1;
						pulse_nxt[3] = 1'b1;
					end
				end else if (cnt_r == `CFC_DELIM_LAST) begin
					state_nxt = cfc_pkg::st_inter;
					cnt_nxt = 4'h0;
				end else
					cnt_nxt = cnt_r + 4'h1;
			end
			default: state_nxt = cfc_pkg::st_idle;
			endcase
		end
		if (sof) begin
			state_nxt = cfc_pkg::st_frame;
			pos_nxt = 7'h01;
			run_nxt = 3'h1;
			last_nxt = 1'b0;
			done_nxt = 1'b0;
			crc_bad_nxt = 1'b0;
			crc_clr = 1'b1;
			id_nxt = 29'h0;
			ide_nxt = 1'b0;
			rtr_nxt = 1'b0;
			dlc_nxt = 4'h0;
			data_nxt = 64'h0;
			tx_sh_nxt = sh_plain;
			tx_bit_nxt = txing_r ? sh_plain[102] : 1'b1;
		end
		if (launch) begin
			txing_nxt = 1'b1;
			tx_sh_nxt = tx_load;
			tx_bit_nxt = 1'b0;
		end
		// flags come only from these reactions, never on request
		if (ovl_go) begin
			state_nxt = cfc_pkg::st_flag;
			cnt_nxt = 4'h0;
			ovl_nxt = 1'b1;
			tx_bit_nxt = 1'b0;
			pulse_nxt[7] = 1'b0;
		end
		if (fault) begin
			state_nxt = cfc_pkg::st_flag;
			cnt_nxt = 4'h0;
			run_nxt = 3'h0;
			ovl_nxt = 1'b0;
			passive_nxt = err_passive;
			tx_bit_nxt = err_passive;
			txing_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= cfc_pkg::st_idle;
			{pos_r, run_r, last_r, cnt_r, dom_r} <= 18'h0;
			{txing_r, done_r, ovl_r, passive_r, crc_bad_r} <= 5'h0;
			tx_bit_r <= 1'b1;
			tx_sh_r <= 103'h0;
			pulse_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			{pos_r, run_r, last_r, cnt_r, dom_r} <= {pos_nxt, run_nxt, last_nxt, cnt_nxt, dom_nxt};
			{txing_r, done_r, ovl_r, passive_r, crc_bad_r} <=
				{txing_nxt, done_nxt, ovl_nxt, passive_nxt, crc_bad_nxt};
			tx_bit_r <= tx_bit_nxt;
			tx_sh_r <= tx_sh_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// captures are only read at rx_valid; reset clears them, and so does sof
	always_ff @(posedge clk) begin
		if (reset)
			{id_r, ide_r, rtr_r, dlc_r, data_r} <= 99'h0;
		else
			{id_r, ide_r, rtr_r, dlc_r, data_r} <= {id_nxt, ide_nxt, rtr_nxt, dlc_nxt, data_nxt};
	end

	logic ovl_start_r;
	always_ff @(posedge clk) begin
		if (reset)
			ovl_start_r <= 1'b0;
		else
			ovl_start_r <= ovl_go;
	end

	assign tx_bit = tx_bit_r;
	assign {rx_valid, tx_lost, tx_done, err_ack, err_form, err_crc, err_stuff, err_bit} = pulse_r;
	assign ovl_start = ovl_start_r;
	assign rx_id = id_r;
	assign rx_ide = ide_r;
	assign rx_rtr = rtr_r;
	assign rx_dlc = dlc_r;
	assign rx_data = data_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence eof_close_s;
		state_r == cfc_pkg::st_eof && cnt_r == `CFC_EOF_LAST && bit_tick && rx_bit && txing_r;
	endsequence

	sof_first_a: assert property ($rose(txing_r) |-> !tx_bit_r)
		else $error("transmission did not open with dominant sof");
	stuff_insert_a: assert property (state_r == cfc_pkg::st_frame && txing_r && run_r == 3'h5
		|-> tx_bit_r != last_r)
		else $error("stuff bit not opposite to the run");
	fixed_rec_a: assert property (state_r inside {cfc_pkg::st_crcdel, cfc_pkg::st_ackdel,
		cfc_pkg::st_eof, cfc_pkg::st_echo, cfc_pkg::st_delim} |-> tx_bit_r)
		else $error("fixed recessive field driven dominant");
	ack_slot_a: assert property (state_r == cfc_pkg::st_ack |-> tx_bit_r == (txing_r || crc_bad_r))
		else $error("ack slot level wrong");
	flag_dom_a: assert property (state_r == cfc_pkg::st_flag && (ovl_r || !passive_r) |-> !tx_bit_r)
		else $error("active flag bit not dominant");
	pasv_flag_a: assert property (state_r == cfc_pkg::st_flag && passive_r && !ovl_r |-> tx_bit_r)
		else $error("passive flag bit not recessive");
	ovl_place_a: assert property ($rose(ovl_start_r) |-> $past(state_r) inside
		{cfc_pkg::st_eof, cfc_pkg::st_inter, cfc_pkg::st_delim})
		else $error("overload outside interframe space");
	eof_done_a: assert property (eof_close_s |=> tx_done && state_r == cfc_pkg::st_inter)
		else $error("frame end not reported");
	crc_err_a: assert property (err_crc |-> $past(crc_bad_r) && state_r == cfc_pkg::st_flag)
		else $error("crc error without mismatch");
endmodule

// ### design/cfc_defs.svh
/*
 * Constants of the CAN frame codec: field positions, lengths, CRC figures.
 * Assumes the includer works on unstuffed bit positions counted from SOF = 0.
 */
`ifndef CFC_DEFS_SVH
`define CFC_DEFS_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define CFC_STD_HDR 7'h13
`define CFC_EXT_HDR 7'h27
`define CFC_CRC_LEN 7'h0f
`define CFC_DLC_LEN 7'h04
`define CFC_MAX_DATA 7'h40
`define CFC_POS_ID_END 7'h0b
`define CFC_POS_SRR_RTR 7'h0c
`define CFC_POS_IDE 7'h0d
`define CFC_POS_EID_END 7'h1f
`define CFC_POS_XRTR 7'h20

// ----------------------------------------
// crc
// ----------------------------------------
`define CFC_CRC_POLY 15'h4599
`define CFC_CRC_INIT 15'h0000
`define CFC_CRC_GOOD 15'h0000

// ----------------------------------------
// counts in bit times
// ----------------------------------------
`define CFC_STUFF_RUN 3'h5
`define CFC_PASV_RUN 3'h6
`define CFC_FLAG_LAST 4'h5
`define CFC_FLAG_LEN 4'h6
`define CFC_ECHO_MAX 4'hc
`define CFC_DELIM_LAST 4'h7
`define CFC_EOF_VALID 4'h5
`define CFC_EOF_LAST 4'h6
`define CFC_INTER_LAST 4'h2

`endif

// ### design/cfc_pkg.sv
/*
 * Types of the CAN frame codec.
 * Assumes cfc_defs.svh supplies the numeric constants.
 */
package cfc_pkg;
	// gray along idle-frame-...-intermission, flag branch apart
	typedef enum logic [3:0] {
		st_idle = 4'h0,
		st_frame = 4'h1,
		st_crcdel = 4'h3,
		st_ack = 4'h2,
		st_ackdel = 4'h6,
		st_eof = 4'h7,
		st_inter = 4'h5,
		st_flag = 4'hc,
		st_echo = 4'hd,
		st_delim = 4'hf
	} cfc_state_e;
endpackage

// ### design/cfc_crc15.sv
/*
 * Serial 15-bit CRC of the CAN frame codec.
 * Assumes en and clr are one-cycle strobes on clk, one per unstuffed bit.
 */
`timescale 1ns/100ps
`include "cfc_defs.svh"
module cfc_crc15 (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic clr, // restart with din as first bit
	input wire logic en, // fold din in
	input wire logic din, // unstuffed bus bit
	output logic [14:0] crc_nxt // remainder including din
);
	logic [14:0] crc_r;

	function automatic logic [14:0] crc_step(input logic [14:0] c, input logic d);
		crc_step = {c[13:0], 1'b0} ^ ((c[14] ^ d) ? `CFC_CRC_POLY : `CFC_CRC_INIT);
	endfunction

	assign crc_nxt = crc_step(crc_r, din);

	always_ff @(posedge clk) begin
		if (reset)
			crc_r <= `CFC_CRC_INIT;
		else if (clr)
			crc_r <= crc_step(`CFC_CRC_INIT, din);
		else if (en)
			crc_r <= crc_nxt;
	end
endmodule

// ### verification/cfc_node_model.sv
/*
 * Far-side CAN node: bit strobe source, wired-AND bus and a bit pattern player.
 * Assumes the codec samples rx_bit only while bit_tick is high.
 */
`timescale 1ns/100ps
module cfc_node_model (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic go, // play pattern from next tick
	input wire logic [255:0] pat, // bit 0 goes first
	input wire logic [8:0] len, // pattern length in bits
	input wire logic dut_tx, // codec drive level
	output logic bit_tick, // one pulse per bit
	output logic rx_bit // resolved bus level
);
	logic [1:0] cnt_r;
	logic [8:0] idx_r;
	logic drv_r;
	logic play;
	// ----------------------------------------
	// bus
	// ----------------------------------------
	assign bit_tick = (cnt_r == 2'h3);
	assign play = go && (idx_r < len);
	assign rx_bit = dut_tx & drv_r;
	// released line falls back to recessive, as the bus termination does
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= 2'h0;
			idx_r <= 9'h000;
			drv_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			if (!go)
				idx_r <= 9'h000;
			else if (bit_tick && play)
				idx_r <= idx_r + 9'h001;
			if (bit_tick)
				drv_r <= !play || pat[idx_r[7:0]];
		end
	end
endmodule

// ### verification/can_frame_codec_test.sv
/*
 * Self-checking bench of the CAN frame codec against one far-side node model.
 * Assumes cfc_defs.svh is on the include path; one bit lasts four clocks.
 */
`timescale 1ns/100ps
`include "cfc_defs.svh"
module can_frame_codec_test;
	logic clk = 1'b0, reset = 1'b1, tx_req = 1'b0, tx_ide = 1'b0, tx_rtr = 1'b0;
	logic err_passive = 1'b0, go = 1'b0, bit_tick, rx_bit;
	logic [28:0] tx_id = 29'h0, rx_id;
	logic [3:0] tx_dlc = 4'h0, rx_dlc;
	logic [63:0] tx_data = 64'h0, rx_data;
	logic [255:0] pat = '1, fb, obs;
	logic [8:0] plen = 9'h000;
	logic tx_bit, tx_done, tx_lost, rx_valid, rx_ide, rx_rtr;
	logic err_bit, err_stuff, err_crc, err_form, err_ack, ovl_start;
	int fail_count = 0, comparisons = 0, cycles = 0;
	int flen, ack_ix, k, done_at, valid_at, crc_at, ovl_at, form_at, lost_at;

	always #2.5 clk = ~clk;
	cfc_node_model peer (.clk(clk), .reset(reset), .go(go), .pat(pat), .len(plen),
		.dut_tx(tx_bit), .bit_tick(bit_tick), .rx_bit(rx_bit));
	cfc_codec dut (.clk(clk), .reset(reset), .bit_tick(bit_tick), .rx_bit(rx_bit),
		.err_passive(err_passive), .tx_req(tx_req), .tx_ide(tx_ide), .tx_rtr(tx_rtr),
		.tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_bit(tx_bit),
		.tx_done(tx_done), .tx_lost(tx_lost), .rx_valid(rx_valid), .rx_ide(rx_ide),
		.rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
		.err_bit(err_bit), .err_stuff(err_stuff), .err_crc(err_crc),
		.err_form(err_form), .err_ack(err_ack), .ovl_start(ovl_start));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cmp_bits(input int a, input int b, input logic [255:0] e);
		for (int i = a; i <= b; i++)
			check(obs[i], e[i]);
	endtask

	// expected stuffed frame up to the end of EOF, in send order from fb[0]
	task automatic build(input logic ide, rtr, r1, r0, bad, input logic [28:0] id,
		input logic [3:0] dlc, input logic [63:0] d);
		logic raw [$];
		logic [14:0] crc;
		logic nx, last;
		int n, run;
		n = rtr ? 0 : (dlc > 4'h8 ? 8 : dlc);
		raw.push_back(1'b0);
		for (int i = 10; i >= 0; i--)
			raw.push_back(ide ? id[i + 18] : id[i]);
		raw.push_back(ide | rtr);
		raw.push_back(ide);
		if (ide) begin
			for (int i = 17; i >= 0; i--)
				raw.push_back(id[i]);
			raw.push_back(rtr);
			raw.push_back(r1);
		end
		raw.push_back(r0);
		for (int i = 3; i >= 0; i--)
			raw.push_back(dlc[i]);
		for (int i = 8 * n - 1; i >= 0; i--)
			raw.push_back(d[i]);
		crc = 15'h0000;
		foreach (raw[i]) begin
			nx = raw[i] ^ crc[14];
			crc = {crc[13:0], 1'b0} ^ (nx ? `CFC_CRC_POLY : 15'h0000);
		end
		crc[0] = crc[0] ^ bad;
		for (int i = 14; i >= 0; i--)
			raw.push_back(crc[i]);
		fb = '1;
		flen = 0;
		run = 0;
		last = 1'b1;
		foreach (raw[i]) begin
			fb[flen] = raw[i];
			flen++;
			run = (raw[i] == last) ? run + 1 : 1;
			last = raw[i];
			if (run == 5) begin
				fb[flen] = ~last;
				flen++;
				last = ~last;
				run = 1;
			end
		end
		ack_ix = flen + 1;
		flen = flen + 10;
	endtask

	// plays pat from the next bit and records tx_bit per bit in obs
	// sampled at the falling edge, where tx_bit and the pulses are settled
	task automatic run(input logic req, input int nbits);
		logic drop;
		drop = 1'b0;
		k = -1;
		{done_at, valid_at, crc_at, ovl_at, form_at, lost_at} = {6{-9}};
		@(negedge clk iff bit_tick);
		@(posedge clk);
		go <= 1'b1;
		tx_req <= req;
		while (k < nbits) begin
			@(negedge clk);
			if (bit_tick) begin
				if (k >= 0)
					obs[k] = tx_bit;
				k++;
			end
			if (tx_done)
				done_at = k - 1;
			if (tx_lost)
				lost_at = k - 1;
			if (tx_done | tx_lost)
				drop = 1'b1;
			if (rx_valid)
				valid_at = k - 1;
			if (err_crc)
				crc_at = k - 1;
			if (ovl_start)
				ovl_at = k - 1;
			if (err_form | err_bit | err_stuff | err_ack)
				form_at = k - 1;
			@(posedge clk);
			if (drop)
				tx_req <= 1'b0;
		end
		go <= 1'b0;
	endtask

	task automatic tx_frame(input logic ide, rtr, input logic [28:0] id,
		input logic [3:0] dlc, input logic [63:0] d);
		@(posedge clk);
		tx_ide <= ide;
		tx_rtr <= rtr;
		tx_id <= id;
		tx_dlc <= dlc;
		tx_data <= d;
		build(ide, rtr, 1'b0, 1'b0, 1'b0, id, dlc, d);
		pat <= ~(256'h1 << ack_ix);
		plen <= 9'(flen);
		run(1'b1, flen + 30);
		cmp_bits(0, flen - 1, fb);
		check(done_at, flen - 1);
		check(form_at, -9);
		check(lost_at, -9);
	endtask

	task automatic rx_play(input int extra);
		pat <= fb;
		plen <= 9'(flen + extra);
		run(1'b0, flen + 30);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_tx_std();
		tx_frame(1'b0, 1'b0, 29'h000001f, 4'h2, 64'h00ff);
	endtask

	task automatic t_tx_ext();
		tx_frame(1'b1, 1'b0, 29'h0abcdef5, 4'h9, 64'hfedcba9876543210);
	endtask

	task automatic t_rx_std();
		build(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 29'h5a3, 4'hc, 64'h0123456789abcdef);
		rx_play(0);
		cmp_bits(0, flen - 1, ~(256'h1 << ack_ix));
		check(valid_at, flen - 2);
		check({rx_ide, rx_rtr, rx_dlc, rx_id}, {2'b00, 4'hc, 29'h5a3});
		check(rx_data, 64'h0123456789abcdef);
		check(ovl_at, -9);
	endtask

	// far node with a lower identifier wins at the first identifier bit
	task automatic t_arb_lost();
		@(posedge clk);
		tx_ide <= 1'b0;
		tx_rtr <= 1'b0;
		tx_id <= 29'h7ff;
		tx_dlc <= 4'h0;
		tx_data <= 64'h0;
		build(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 29'h3ff, 4'h0, 64'h0);
		pat <= fb;
		plen <= 9'(flen);
		run(1'b1, flen + 30);
		check(lost_at, 1);
		check(done_at, -9);
		check(obs[ack_ix], 1'b0);
		check(valid_at, flen - 2);
	endtask

	task automatic t_rx_ext_rtr();
		build(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 29'h1234567, 4'h3, 64'h0);
		rx_play(0);
		check(obs[ack_ix], 1'b0);
		check(valid_at, flen - 2);
		check({rx_ide, rx_rtr, rx_dlc, rx_id}, {2'b11, 4'h3, 29'h1234567});
		check(rx_data, 64'h0);
	endtask

	task automatic t_crc_active();
		build(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 29'h2aa, 4'h1, 64'h3c);
		fb[ack_ix + 2 +: 10] = 10'h000;
		rx_play(2);
		check(obs[ack_ix], 1'b1);
		check(crc_at, ack_ix + 1);
		cmp_bits(ack_ix + 2, ack_ix + 7, '0);
		cmp_bits(ack_ix + 8, ack_ix + 27, '1);
		check({form_at, valid_at, ovl_at}, {3{-9}});
	endtask

	task automatic t_crc_passive();
		@(posedge clk);
		err_passive <= 1'b1;
		build(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 29'h155, 4'h0, 64'h0);
		rx_play(0);
		check(crc_at, ack_ix + 1);
		cmp_bits(ack_ix, ack_ix + 27, '1);
		err_passive <= 1'b0;
	endtask

	// dominant at EOF bit 7, intermission bit 1 and bit 2 in turn
	task automatic t_overload();
		for (int j = 0; j < 3; j++) begin
			build(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 29'h321, 4'h1, 64'h81);
			fb[flen - 1 + j] = 1'b0;
			rx_play(j);
			check(ovl_at, flen - 1 + j);
			cmp_bits(flen + j, flen + j + 5, '0);
			check(obs[flen + j + 6], 1'b1);
		end
	endtask

	// ----------------------------------------
	// sequence and timeout
	// ----------------------------------------
	// ceiling well above ten frames of under 200 bits at four clocks each
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (40) @(posedge clk);
		t_tx_std();
		t_tx_ext();
		t_rx_std();
		t_rx_ext_rtr();
		t_arb_lost();
		t_crc_active();
		t_crc_passive();
		t_overload();
		end_of_test();
	end
endmodule
